// >>> bench/testbench.sv
// self-checking testbench for the shift execution stage
`default_nettype none

module testbench
  import slar_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk_i;
  logic              reset_i;
  logic              valid_i;
  logic [DATA_W-1:0] instr_i;
  logic [DATA_W-1:0] first_source_reg_i;
  logic [DATA_W-1:0] second_source_reg_i;
  logic              wr_en_o;
  logic [REG_W-1:0]  dest_reg_o;
  logic [DATA_W-1:0] result_o;
  logic              exp_wr;
  logic [REG_W-1:0]  exp_dest;
  logic [DATA_W-1:0] exp_res;
  logic [DATA_W:0]   exp_now;
  int                n_errors;
  int                n_tests;

  localparam logic [OPX_W-1:0] SH_OPX [3]  = '{OPX_SLLI, OPX_SRA, OPX_SRAI};
  localparam logic [OPX_W-1:0] BAD_OPX [5] = '{6'h13, 6'h1B, 6'h1A, 6'h02, 6'h0B};

  slar_shift_unit i_slar_shift_unit (
    .clk_i               (clk_i),
    .reset_i             (reset_i),
    .valid_i             (valid_i),
    .instr_i             (instr_i),
    .first_source_reg_i  (first_source_reg_i),
    .second_source_reg_i (second_source_reg_i),
    .wr_en_o             (wr_en_o),
    .dest_reg_o          (dest_reg_o),
    .result_o            (result_o)
  );

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  // top bit says whether the word is an accepted shift
  function automatic logic [DATA_W:0] f_exp(input logic [DATA_W-1:0] ins, a, b);
    logic [SHAMT_W-1:0] imm;
    imm = ins[IMM_MSB:IMM_LSB];
    if (ins[OP_MSB:OP_LSB] !== OP_RTYPE) return {1'b0, 32'h0000_0000};
    case (ins[OPX_MSB:OPX_LSB])
      OPX_SLLI: return {1'b1, a << imm};
      OPX_SRA:  return {1'b1, $signed(a) >>> b[4:0]};
      OPX_SRAI: return {1'b1, $signed(a) >>> imm};
      default:  return {1'b0, 32'h0000_0000};
    endcase
  endfunction

  // register indices of the sources are random: the block must not care
  function automatic logic [DATA_W-1:0] mk(input logic [5:0] opx, input logic [4:0] d, imm,
                                           input logic [5:0] op);
    return {10'($urandom), d, opx, imm, op};
  endfunction

  assign exp_now = f_exp(instr_i, first_source_reg_i, second_source_reg_i);

  // expected outputs one edge after the inputs are taken
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      exp_wr   <= 1'b0;
      exp_dest <= DEST_RST;
      exp_res  <= RESULT_RST;
    end else begin
      exp_wr <= valid_i && exp_now[DATA_W];
      if (valid_i && exp_now[DATA_W]) begin
        exp_dest <= instr_i[DEST_MSB:DEST_LSB];
        exp_res  <= exp_now[DATA_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // comparison
  // ----------------------------------------------------------------
  task automatic note(input bit bad, input logic [DATA_W-1:0] e, g);
    n_tests++;
    if (bad) begin
      n_errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_flag(input logic g, e);
    note(g !== e, 32'(e), 32'(g));
  endtask
  task automatic chk_dest(input logic [REG_W-1:0] g, e);
    note(g !== e, 32'(e), 32'(g));
  endtask
  task automatic chk_res(input logic [DATA_W-1:0] g, e);
    note(g !== e, e, g);
  endtask

  // sample on the falling edge, well away from the launching edge
  always @(negedge clk_i) begin
    if (!reset_i) begin
      chk_flag(wr_en_o, exp_wr);
      chk_dest(dest_reg_o, exp_dest);
      chk_res(result_o, exp_res);
    end
  end

  task automatic issue(input logic v, input logic [DATA_W-1:0] ins, a, b);
    @(posedge clk_i);
    valid_i             <= v;
    instr_i             <= ins;
    first_source_reg_i  <= a;
    second_source_reg_i <= b;
  endtask

  task automatic end_sim();
    $display("errors %0d, comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, stimulus
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // the sequence needs about 400 cycles; over twelve times that means a hang
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    end_sim();
  end

  initial begin
    logic [31:0]      r;
    logic [OPX_W-1:0] opx;
    n_errors = 0;
    n_tests = 0;
    reset_i = 1'b1;
    valid_i = 1'b0;
    instr_i = '0;
    first_source_reg_i = '0;
    second_source_reg_i = '0;
    void'($urandom(5458));
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    // boundary amounts, negative and positive data, junk in upper amount bits
    foreach (SH_OPX[k]) begin
      foreach (BAD_OPX[j]) begin
        r = {27'($urandom), 5'(j * 7 + k)};
        issue(1'b1, mk(SH_OPX[k], 5'(j + 1), r[4:0], OP_RTYPE), 32'h8765_4321, r);
        issue(1'b1, mk(SH_OPX[k], 5'h1F, 5'h1F, OP_RTYPE), 32'h9000_0001, 32'hFFFF_FFFF);
        issue(1'b1, mk(SH_OPX[k], 5'h03, 5'h10, OP_RTYPE), 32'h7FFF_FFFF, 32'hFFFF_FFE0);
        // neighbouring encodings and idle slots must not write
        issue(1'b1, mk(BAD_OPX[j], 5'h0A, 5'h02, OP_RTYPE), 32'h1234_5678, 32'h0000_0001);
        issue(1'b1, mk(SH_OPX[k], 5'h0B, 5'h02, 6'h3B), 32'h1234_5678, 32'h0000_0001);
        issue(1'b0, mk(SH_OPX[k], 5'h0C, 5'h02, OP_RTYPE), 32'h1234_5678, 32'h0000_0001);
      end
    end
    // random mix, mostly shifts, back to back
    for (int i = 0; i < 300; i++) begin
      r = $urandom;
      opx = (r[1:0] == 2'h3) ? 6'($urandom) : SH_OPX[r[3:2] % 3];
      issue(r[6:4] != 3'h0, mk(opx, 5'($urandom), 5'($urandom),
            (r[9:7] == 3'h0) ? 6'($urandom) : OP_RTYPE), $urandom, $urandom);
      // reset in mid-run while a write is pending
      if (i == 150) begin
        reset_i <= 1'b1;
        issue(1'b1, mk(OPX_SLLI, 5'h11, 5'h04, OP_RTYPE), 32'hFFFF_FFFF, 32'h0);
        issue(1'b1, mk(OPX_SRAI, 5'h12, 5'h04, OP_RTYPE), 32'hFFFF_FFFF, 32'h0);
        // release on an idle slot: no shift attempt straddles the release edge
        issue(1'b0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        reset_i <= 1'b0;
      end
    end
    // same operand and amount twice, source fields differ: result must hold
    issue(1'b1, mk(OPX_SRAI, 5'h07, 5'h09, OP_RTYPE), 32'hC000_0000, 32'h0000_0003);
    issue(1'b1, mk(OPX_SRAI, 5'h07, 5'h09, OP_RTYPE), 32'hC000_0000, 32'h0000_001C);
    issue(1'b0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    end_sim();
  end
endmodule

`default_nettype wire

// >>> verilog/slar_barrel.sv
// logarithmic barrel shifter: left logical or right arithmetic
`default_nettype none

module slar_barrel
  import slar_pkg::*;
(
  input  wire logic [DATA_W-1:0]  data_i,
  input  wire logic [SHAMT_W-1:0] amount_i,
  input  wire logic               left_i,
  output logic      [DATA_W-1:0]  result_o
);

  // ----------------------------------------------------------------
  // bit reversal lets one right shifter serve both directions
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rev_in;
  logic [DATA_W-1:0] rev_out;
  logic [DATA_W-1:0] stage [SHAMT_W+1];
  logic              fill;

  // left shifts always fill with zero, right shifts with the sign
  assign fill = left_i ? 1'b0 : data_i[DATA_W-1];

  for (genvar i = 0; i < DATA_W; i++) begin : g_rev
    assign rev_in[i]  = data_i[DATA_W-1-i];
    assign rev_out[i] = stage[SHAMT_W][DATA_W-1-i];
  end

  assign stage[0] = left_i ? rev_in : data_i;

  // one stage per amount bit, shifting by 1, 2, 4, 8, 16
  for (genvar s = 0; s < SHAMT_W; s++) begin : g_stage
    localparam int unsigned STEP = 1 << s;
    assign stage[s+1] = amount_i[s] ?
                        {{STEP{fill}}, stage[s][DATA_W-1:STEP]} : stage[s];
  end

  assign result_o = left_i ? rev_out : stage[SHAMT_W];

endmodule

`default_nettype wire

// >>> verilog/slar_pkg.sv
// shared constants for the shift-left / arithmetic-right datapath
`default_nettype none

package slar_pkg;

  // ----------------------------------------------------------------
  // data and field widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned SHAMT_W = 5;
  localparam int unsigned REG_W   = 5;
  localparam int unsigned OPX_W   = 6;
  localparam int unsigned OP_W    = 6;

  // ----------------------------------------------------------------
  // register-format instruction field positions
  // ----------------------------------------------------------------
  localparam int unsigned SRC_A_MSB = 31;
  localparam int unsigned SRC_A_LSB = 27;
  localparam int unsigned SRC_B_MSB = 26;
  localparam int unsigned SRC_B_LSB = 22;
  localparam int unsigned DEST_MSB  = 21;
  localparam int unsigned DEST_LSB  = 17;
  localparam int unsigned OPX_MSB   = 16;
  localparam int unsigned OPX_LSB   = 11;
  localparam int unsigned IMM_MSB   = 10;
  localparam int unsigned IMM_LSB   = 6;
  localparam int unsigned OP_MSB    = 5;
  localparam int unsigned OP_LSB    = 0;

  // ----------------------------------------------------------------
  // opcode encodings
  // ----------------------------------------------------------------
  localparam logic [OP_W-1:0]  OP_RTYPE  = 6'h3A;
  localparam logic [OPX_W-1:0] OPX_SLLI  = 6'h12;
  localparam logic [OPX_W-1:0] OPX_SRA   = 6'h3B;
  localparam logic [OPX_W-1:0] OPX_SRAI  = 6'h3A;

  // ----------------------------------------------------------------
  // reset values of the result stage
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;
  localparam logic [REG_W-1:0]  DEST_RST   = 5'h00;

endpackage

`default_nettype wire

// >>> verilog/slar_shift_unit.sv
// shift execution stage: decode, shift and registered write-back
`default_nettype none

// Function
// - immediate left shift fills zeroes
// - register right shift replicates sign bit
// - only low five amount bits used
// - immediate right shift copies sign bit
// - immediate amount is unsigned five bits
// - result written to destination index
// - opcode 0x3a with extended opcode selects
module slar_shift_unit
  import slar_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              valid_i,
  input  wire logic [DATA_W-1:0] instr_i,
  input  wire logic [DATA_W-1:0] first_source_reg_i,
  input  wire logic [DATA_W-1:0] second_source_reg_i,
  output logic                   wr_en_o,
  output logic      [REG_W-1:0]  dest_reg_o,
  output logic      [DATA_W-1:0] result_o
);

  // ----------------------------------------------------------------
  // field extraction
  // ----------------------------------------------------------------
  logic [OP_W-1:0]    op_field;
  logic [OPX_W-1:0]   opx_field;
  logic [REG_W-1:0]   dest_field;
  logic [SHAMT_W-1:0] imm_shift_amount;

  // fixed layout; words of other formats are dropped by the opcode check in decode
  assign op_field         = instr_i[OP_MSB:OP_LSB];
  assign opx_field        = instr_i[OPX_MSB:OPX_LSB];
  assign dest_field       = instr_i[DEST_MSB:DEST_LSB];
  assign imm_shift_amount = instr_i[IMM_MSB:IMM_LSB];

  // ----------------------------------------------------------------
  // operation decode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SLAR_OP_NONE,
    SLAR_OP_SLLI,
    SLAR_OP_SRA,
    SLAR_OP_SRAI
  } slar_op_e;

  slar_op_e           op_sel;
  logic               nxt_wr_en;
  logic [SHAMT_W-1:0] amount;
  logic               shift_left;
  logic [DATA_W-1:0]  shifted;

  // other extended opcodes belong to other units: no write, no trap
  always_comb begin
    op_sel = SLAR_OP_NONE;
    if (valid_i && op_field == OP_RTYPE) begin
      if (opx_field == OPX_SLLI) begin
        op_sel = SLAR_OP_SLLI;
      end else if (opx_field == OPX_SRA) begin
        op_sel = SLAR_OP_SRA;
      end else if (opx_field == OPX_SRAI) begin
        op_sel = SLAR_OP_SRAI;
      end
    end
  end

  // amount source and direction for the shared shifter
  always_comb begin
    amount     = imm_shift_amount;
    shift_left = 1'b0;
    nxt_wr_en  = 1'b1;
    case (op_sel)
      SLAR_OP_SLLI: begin
        shift_left = 1'b1;
      end
      SLAR_OP_SRA: begin
        amount = second_source_reg_i[SHAMT_W-1:0];
      end
      SLAR_OP_SRAI: begin
        amount = imm_shift_amount;
      end
      default: begin
        nxt_wr_en = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // shared shifter; one instance keeps area down versus three
  // ----------------------------------------------------------------
  slar_barrel u_barrel (
    .data_i   (first_source_reg_i),
    .amount_i (amount),
    .left_i   (shift_left),
    .result_o (shifted)
  );

  // ----------------------------------------------------------------
  // write-back stage
  // ----------------------------------------------------------------
  logic              wr_en_ff;
  logic [REG_W-1:0]  dest_ff;
  logic [DATA_W-1:0] result_ff;

  // write strobe: one cycle per accepted shift
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_en_ff <= 1'b0;
    end else begin
      wr_en_ff <= nxt_wr_en;
    end
  end

  // result and index only move on a decoded shift, saving toggles
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dest_ff   <= DEST_RST;
      result_ff <= RESULT_RST;
    end else if (nxt_wr_en) begin
      dest_ff   <= dest_field;
      result_ff <= shifted;
    end
  end

  assign wr_en_o    = wr_en_ff;
  assign dest_reg_o = dest_ff;
  assign result_o   = result_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic is_slli;
  logic is_sra;
  logic is_srai;

  assign is_slli = valid_i && op_field == OP_RTYPE && opx_field == OPX_SLLI;
  assign is_sra  = valid_i && op_field == OP_RTYPE && opx_field == OPX_SRA;
  assign is_srai = valid_i && op_field == OP_RTYPE && opx_field == OPX_SRAI;

  // left shift value
  property p_slli_value;
    @(posedge clk_i) disable iff (reset_i)
    is_slli |=> result_o == ($past(first_source_reg_i) << $past(imm_shift_amount));
  endproperty
  a_slli_value: assert property (p_slli_value)
    else $error("immediate left shift result wrong");

  // vacated low bits are zero
  property p_slli_zero_fill;
    @(posedge clk_i) disable iff (reset_i)
    is_slli && imm_shift_amount != 5'h00 |=>
      ((result_o << (6'h20 - {1'b0, $past(imm_shift_amount)})) == 32'h0000_0000);
  endproperty
  a_slli_zero_fill: assert property (p_slli_zero_fill)
    else $error("left shift did not fill low bits with zero");

  // register arithmetic right shift value
  property p_sra_value;
    @(posedge clk_i) disable iff (reset_i)
    is_sra |=> result_o == DATA_W'($signed($past(first_source_reg_i))
                                   >>> $past(second_source_reg_i[SHAMT_W-1:0]));
  endproperty
  a_sra_value: assert property (p_sra_value)
    else $error("register arithmetic right shift result wrong");

  // upper amount bits ignored: zero low bits pass the operand through
  property p_sra_upper_ignored;
    @(posedge clk_i) disable iff (reset_i)
    is_sra && second_source_reg_i[SHAMT_W-1:0] == 5'h00 |=>
      result_o == $past(first_source_reg_i);
  endproperty
  a_sra_upper_ignored: assert property (p_sra_upper_ignored)
    else $error("upper bits of shift amount affected result");

  // immediate arithmetic right shift value
  property p_srai_value;
    @(posedge clk_i) disable iff (reset_i)
    is_srai |=> result_o == DATA_W'($signed($past(first_source_reg_i))
                                    >>> $past(imm_shift_amount));
  endproperty
  a_srai_value: assert property (p_srai_value)
    else $error("immediate arithmetic right shift result wrong");

  // amount with top bit set is large, never negative
  property p_imm_unsigned;
    @(posedge clk_i) disable iff (reset_i)
    is_srai && imm_shift_amount[SHAMT_W-1] |=>
      result_o[DATA_W-1:DATA_W-17] == {17{$past(first_source_reg_i[DATA_W-1])}};
  endproperty
  a_imm_unsigned: assert property (p_imm_unsigned)
    else $error("immediate amount treated as signed");

  // write strobe and destination index follow the instruction
  property p_writeback;
    @(posedge clk_i) disable iff (reset_i)
    (is_slli || is_sra || is_srai) |=>
      wr_en_o && dest_reg_o == $past(instr_i[DEST_MSB:DEST_LSB]);
  endproperty
  a_writeback: assert property (p_writeback)
    else $error("shift result not written to destination");

  // anything outside the three encodings never writes
  property p_decode_only;
    @(posedge clk_i) disable iff (reset_i)
    !(is_slli || is_sra || is_srai) |=> !wr_en_o;
  endproperty
  a_decode_only: assert property (p_decode_only)
    else $error("write strobe without a decoded shift");

  // source B field plays no part in the immediate arithmetic right shift
  property p_layout_imm;
    @(posedge clk_i) disable iff (reset_i)
    is_srai ##1 is_srai && $stable(first_source_reg_i) && $stable(imm_shift_amount)
      |=> $stable(result_o);
  endproperty
  a_layout_imm: assert property (p_layout_imm)
    else $error("immediate shift depends on unrelated fields");

endmodule

`default_nettype wire
